// ===== clock_source_ctrl.v
// Behaviour
// [RQ1] method 00: pins become general ports
// [RQ2] bits 5:4 select low, high, pin source
// [RQ3] refuse select 10 when no pins
// [RQ4] bits 7:6 divide cpu clock 1,2,4,8
// [RQ5] undivided source feeds peripherals
// [RQ6] reset: low-speed source, divide by eight
// [RQ7] high-speed oscillator stopped after reset
// [RQ8] pin oscillator runs after reset itself
// [RQ9] software clears run bit of used source
// [RQ10] method selects resonator, 32k, external
// [RQ11] software waits for pin oscillator stability
// [RQ12] stop-disable option ignores low-speed stop
// [RQ13] high-speed stop bit resets to one
`timescale 1ns/1ns
`include "clkgen_map.vh"
module clock_source_ctrl
(
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // avalon-mm slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // factory option words
  input wire [7:0] factory_option_word_one,
  input wire [7:0] factory_option_word_two,
  // oscillator source ticks, one clk_sys pulse per edge; ext_clk_in is a raw level
  input wire low_osc_tick,
  input wire high_osc_tick,
  input wire main_osc_tick,
  input wire sub_osc_tick,
  input wire ext_clk_in,
  // oscillator enables
  output reg low_osc_run_r,
  output reg high_osc_run_r,
  output reg main_osc_run_r,
  output reg sub_osc_run_r,
  // clock outputs as ticks
  output reg periph_tick_r,
  output reg cpu_tick_r,
  // port2 line0: output port or osc output
  input wire port2_line0_out,
  output reg port2_line0_o,
  output reg port2_line0_oe,
  // port2 line1: i/o port or osc input
  input wire port2_line1_in,
  input wire port2_line1_out,
  input wire port2_line1_dir,
  output reg port2_line1_o,
  output reg port2_line1_oe,
  output reg port2_line1_i_r
);
  reg [7:0] clock_mode_reg;
  reg [1:0] method_r;
  reg ls_stop_en_r;
  reg ack_r;
  reg [2:0] ext_sync_r;
  reg ext_lvl_r;
  reg src_tick;
  reg [7:0] wr_val;
  reg [7:0] cm_nxt;
  wire div_tick;
  wire [1:0] sel = clock_mode_reg[`CM_SEL_HI:`CM_SEL_LO];
  wire [1:0] divc = clock_mode_reg[`CM_DIV_HI:`CM_DIV_LO];
  wire wr_hit = avs_write && !ack_r;
  wire rd_hit = avs_read && !ack_r;

  // factory options captured while reset is held
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      method_r <= factory_option_word_one[1:0];
      ls_stop_en_r <= factory_option_word_two[`FO2_LS_STOP_EN];
    end
  end

  // external clock input synchroniser, edge once stages 2 and 3 agree
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      ext_sync_r <= 3'h0;
      ext_lvl_r <= 1'b0;
    end
    else
    begin
      ext_sync_r <= {ext_sync_r[1:0], ext_clk_in};
      if (ext_sync_r[2] == ext_sync_r[1])
        ext_lvl_r <= ext_sync_r[2];
    end
  end

  // source mux
  always @*
  begin
    src_tick = 1'b0;
    case (sel)
      `SEL_LOW: src_tick = low_osc_tick && low_osc_run_r; // [RQ2] [RQ9]
      `SEL_HIGH: src_tick = high_osc_tick && high_osc_run_r; // [RQ2] [RQ9]
      `SEL_PIN:
      begin
        case (method_r) // [RQ10]
          `OSC_RES: src_tick = main_osc_tick && main_osc_run_r;
          `OSC_32K: src_tick = sub_osc_tick && sub_osc_run_r;
          // rising edge once stages 2 and 3 both read high
          `OSC_EXT: src_tick = ext_sync_r[2] && ext_sync_r[1] && !ext_lvl_r;
          default: src_tick = 1'b0;
        endcase
      end
      default: src_tick = 1'b0;
    endcase
  end

  // register write filtering
  always @*
  begin
    wr_val = avs_writedata[7:0] & `CM_WMASK;
    cm_nxt = wr_val;
    if (method_r == `OSC_NONE &&
        wr_val[`CM_SEL_HI:`CM_SEL_LO] == `SEL_PIN)
      cm_nxt[`CM_SEL_HI:`CM_SEL_LO] = sel; // [RQ3]
    if (!ls_stop_en_r)
      cm_nxt[`CM_LS_STOP] = 1'b0; // [RQ12]
  end

  // register and bus slave, one wait cycle per access
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      clock_mode_reg <= `CM_RESET; // [RQ6] [RQ13]
      ack_r <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end
    else
    begin
      ack_r <= wr_hit || rd_hit;
      avs_waitrequest <= !(wr_hit || rd_hit);
      // write lands on the edge that shows waitrequest low
      if (avs_write && !avs_waitrequest &&
          avs_address == `ADDR_CLOCK_MODE)
        clock_mode_reg <= cm_nxt;
      if (rd_hit)
      begin
        case (avs_address)
          `ADDR_CLOCK_MODE: avs_readdata <= {24'h0, clock_mode_reg};
          `ADDR_STATUS: avs_readdata <= {24'h0, ls_stop_en_r, method_r,
            low_osc_run_r, high_osc_run_r, main_osc_run_r || sub_osc_run_r,
            sel};
          default: avs_readdata <= 32'h0;
        endcase
      end
    end
  end

  clk_divider u_div
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .src_tick(src_tick),
    .div_code(divc), // [RQ4]
    .cpu_tick(div_tick)
  );

  // oscillator enables, clock and pin outputs
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      low_osc_run_r <= 1'b0;
      high_osc_run_r <= 1'b0; // [RQ7]
      main_osc_run_r <= 1'b0;
      sub_osc_run_r <= 1'b0;
      periph_tick_r <= 1'b0;
      cpu_tick_r <= 1'b0;
      port2_line0_o <= 1'b0;
      port2_line0_oe <= 1'b0;
      port2_line1_o <= 1'b0;
      port2_line1_oe <= 1'b0;
      port2_line1_i_r <= 1'b0;
    end
    else
    begin
      low_osc_run_r <= !clock_mode_reg[`CM_LS_STOP];
      high_osc_run_r <= !clock_mode_reg[`CM_HS_STOP]; // [RQ13]
      // pin bit resets to 0, so it starts alone
      main_osc_run_r <= method_r == `OSC_RES &&
        !clock_mode_reg[`CM_PIN_STOP]; // [RQ8]
      sub_osc_run_r <= method_r == `OSC_32K &&
        !clock_mode_reg[`CM_PIN_STOP]; // [RQ8]
      periph_tick_r <= src_tick; // [RQ5]
      cpu_tick_r <= div_tick;
      port2_line1_i_r <= port2_line1_in;
      if (method_r == `OSC_NONE)
      begin
        port2_line0_o <= port2_line0_out; // [RQ1]
        port2_line0_oe <= 1'b1; // [RQ1]
        port2_line1_o <= port2_line1_out; // [RQ1]
        port2_line1_oe <= port2_line1_dir; // [RQ1]
      end
      else if (method_r == `OSC_EXT)
      begin
        port2_line0_o <= 1'b0;
        port2_line0_oe <= 1'b0;
        port2_line1_o <= port2_line1_out;
        port2_line1_oe <= port2_line1_dir;
      end
      else
      begin
        port2_line0_o <= 1'b0;
        port2_line0_oe <= 1'b0;
        port2_line1_o <= 1'b0;
        port2_line1_oe <= 1'b0;
      end
    end
  end
endmodule // clock_source_ctrl

// ===== clkgen_map.vh
`ifndef CLKGEN_MAP_VH
`define CLKGEN_MAP_VH
// register byte addresses
`define ADDR_CLOCK_MODE 4'h0
`define ADDR_STATUS 4'h4
// clock mode register fields
`define CM_DIV_HI 7
`define CM_DIV_LO 6
`define CM_SEL_HI 5
`define CM_SEL_LO 4
`define CM_PIN_STOP 2
`define CM_HS_STOP 1
`define CM_LS_STOP 0
`define CM_RESET 8'h02
`define CM_WMASK 8'hF7
// source select codes
`define SEL_LOW 2'h0
`define SEL_HIGH 2'h1
`define SEL_PIN 2'h2
// oscillation method codes
`define OSC_NONE 2'h0
`define OSC_RES 2'h1
`define OSC_32K 2'h2
`define OSC_EXT 2'h3
// divider ratio codes
`define DIV_8 2'h0
`define DIV_4 2'h1
`define DIV_2 2'h2
`define DIV_1 2'h3
// factory word two: low-speed stop enable bit
`define FO2_LS_STOP_EN 4
`endif

// ===== clk_divider.v
`timescale 1ns/1ns
`include "clkgen_map.vh"
// counts source ticks and emits one cpu tick per ratio
module clk_divider
(
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // source tick and ratio code
  input wire src_tick,
  input wire [1:0] div_code,
  // divided tick
  output reg cpu_tick
);
  reg [2:0] cnt_r;
  reg [2:0] limit;

  always @*
  begin
    case (div_code)
      `DIV_1: limit = 3'h0;
      `DIV_2: limit = 3'h1;
      `DIV_4: limit = 3'h3;
      default: limit = 3'h7;
    endcase
  end

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt_r <= 3'h0;
      cpu_tick <= 1'b0;
    end
    else
    begin
      cpu_tick <= 1'b0;
      if (src_tick)
      begin
        if (cnt_r >= limit)
        begin
          cnt_r <= 3'h0;
          cpu_tick <= 1'b1;
        end
        else
          cnt_r <= cnt_r + 3'h1;
      end
    end
  end
endmodule // clk_divider

// ===== clock_source_ctrl_assertions.sv
`timescale 1ns/1ns
module csc_checker
(
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // bus
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // options and state
  input wire [7:0] factory_option_word_one,
  input wire [7:0] factory_option_word_two,
  input wire low_osc_run_r,
  input wire high_osc_run_r,
  input wire cpu_tick_r,
  // port2 pins
  input wire port2_line0_out,
  input wire port2_line0_o,
  input wire port2_line0_oe,
  input wire port2_line1_dir,
  input wire port2_line1_oe
);
  wire rd_ok = avs_read && !avs_waitrequest;
  wire no_pins = factory_option_word_one[1:0] == 2'h0;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_req_answered: assert property ((avs_read || avs_write) |->
    ##[0:2] !avs_waitrequest) else $error("no answer");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer too long");
  a_hs_stopped: assert property ($fell(rst) |-> !high_osc_run_r [*3])
    else $error("high osc running");
  a_ls_kept: assert property (!factory_option_word_two[4] |-> ##2 low_osc_run_r)
    else $error("low osc stopped");
  a_line0_port: assert property (no_pins |=> port2_line0_oe &&
    port2_line0_o == $past(port2_line0_out)) else $error("line0 port");
  a_line1_port: assert property (no_pins |=>
    port2_line1_oe == $past(port2_line1_dir)) else $error("line1 port");
  a_pin_refused: assert property (rd_ok && avs_address == 4'h0 && no_pins
    |-> avs_readdata[5:4] != 2'h2) else $error("pin select taken");
  a_resv_zero: assert property (rd_ok && avs_address == 4'h0 |->
    avs_readdata[3] == 1'b0 && avs_readdata[31:8] == 24'h0) else $error("resv");
  cover property (rd_ok && avs_address == 4'h4);
  cover property (cpu_tick_r);
  cover property (avs_write && !avs_waitrequest && no_pins);
endmodule // csc_checker
bind clock_source_ctrl csc_checker csc_chk_u (.*);

// ===== clock_source_ctrl_tb.sv
`timescale 1ns/1ns
module clock_source_ctrl_tb;
  logic clk_sys = 0, rst = 1, avs_read = 0, avs_write = 0, ext_d = 0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, seed = 32'h2240, avs_readdata;
  logic [7:0] factory_option_word_one = 8'h0, factory_option_word_two = 8'h0;
  logic [7:0] rd;
  logic ext_f = 0, rst_q = 1, in_d = 0;
  logic low_osc_tick = 0, high_osc_tick = 0, main_osc_tick = 0;
  logic sub_osc_tick = 0, ext_clk_in = 0, port2_line0_out = 0;
  logic port2_line1_in = 0, port2_line1_out = 0, port2_line1_dir = 0;
  logic avs_waitrequest, low_osc_run_r, high_osc_run_r, main_osc_run_r;
  logic sub_osc_run_r, periph_tick_r, cpu_tick_r, port2_line0_o;
  logic port2_line0_oe, port2_line1_o, port2_line1_oe, port2_line1_i_r;
  int num_errors = 0, comparisons = 0, pcnt = 0, ccnt = 0, scnt = 0;
  logic [2:0] m;
  logic [1:0] eff, d;
  clock_source_ctrl dut_u (.*);
  always #4 clk_sys = ~clk_sys;
  function automatic [31:0] xs(input [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  always @(posedge clk_sys)
  begin
    seed <= xs(seed);
    {low_osc_tick, high_osc_tick, main_osc_tick, sub_osc_tick, ext_clk_in,
      port2_line0_out, port2_line1_in, port2_line1_out,
      port2_line1_dir} <= seed[8:0];
    ext_d <= ext_clk_in;
    ext_f <= (ext_clk_in == ext_d) ? ext_clk_in : ext_f;
    rst_q <= rst;
    in_d <= port2_line1_in;
    if (!rst && !rst_q)
      chk("line1_in", in_d, port2_line1_i_r);
    pcnt <= pcnt + periph_tick_r;
    ccnt <= ccnt + cpu_tick_r;
    scnt <= scnt + (eff == 2'h0 ? low_osc_tick : eff == 2'h1 ? high_osc_tick
      : m == 3'h1 ? main_osc_tick : m == 3'h2 ? sub_osc_tick
      : ext_clk_in & ext_d & !ext_f);
  end
  task automatic bus(input w, input [3:0] a, input [7:0] dt);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, dt};
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic chk(string n, logic [31:0] e, g, int t = 0);
    comparisons++;
    if (t == 0 ? g !== e : (g > e ? g - e : e - g) > t)
    begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task final_report;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #400000;
    num_errors++;
    final_report;
  end
  initial
  begin
    for (m = 0; m < 4; m++)
    begin
      factory_option_word_one <= {6'h0, m[1:0]};
      factory_option_word_two <= {3'h0, m[0], 4'h0};
      rst <= 1'b1;
      eff = 2'h0;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      bus(0, 4'h0, 8'h0);
      chk("mode", 8'h02, rd);
      bus(0, 4'h4, 8'h0);
      chk("status", {m[0], m[1:0], 2'h2, m == 1 || m == 2, 2'h0}, rd);
      bus(1, 4'h0, 8'h01);
      bus(0, 4'h0, 8'h0);
      chk("ls_stop", {7'h0, m[0]}, rd);
      bus(1, 4'h8, 8'hFF);
      bus(0, 4'h8, 8'h0);
      chk("unmapped", 8'h0, rd);
      bus(1, 4'h0, 8'h0);
      for (int k = 0; k < 12; k++)
      begin
        d = k[1:0];
        if (k / 4 != 2 || m != 0) eff = 2'(k / 4);
        bus(1, 4'h0, {d, 2'(k / 4), 4'h0});
        bus(0, 4'h0, 8'h0);
        chk("mode", {d, eff, 4'h0}, rd);
        @(negedge clk_sys);
        {pcnt, ccnt, scnt} = 0;
        repeat (200) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("periph", scnt, pcnt, 4);
        chk("cpu", pcnt, ccnt * (8 >> d), (8 >> d) + 2);
        @(posedge clk_sys);
      end
    end
    final_report;
  end
endmodule // clock_source_ctrl_tb
